// *** dv/memory_address_map_assertions.sv ***
module memory_address_map_assertions
(
    input wire logic core_clk,
    input wire logic rst,
    input wire memory_address_map_pkg::variant_type variant,
    input wire logic pc_advance,
    input wire logic pc_load,
    input wire logic intr_take,
    input wire logic [12:0] pc,
    input wire logic [12:0] prog_addr,
    input wire logic [6:0] direct_offset,
    input wire logic bank_select_high,
    input wire logic data_write,
    input wire logic [7:0] data_wdata,
    input wire logic [7:0] pointer_value,
    input wire logic [1:0] data_region
);
    import memory_address_map_pkg::*;
    // ==========
    // Address checks
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_rst; $fell(rst) |-> pc == 13'h0000; endproperty
    a_rst: assert property (p_rst) else $error("reset pc");
    property p_vec; intr_take |=> pc == 13'h0004; endproperty
    a_vec: assert property (p_vec) else $error("vector");
    property p_adv; pc_advance && !pc_load && !intr_take |=> pc == $past(pc) + 13'h0001; endproperty
    a_adv: assert property (p_adv) else $error("count");
    property p_sml; variant == SIZE_SMALL |-> prog_addr == {2'h0, pc[10:0]}; endproperty
    a_sml: assert property (p_sml) else $error("small");
    property p_mid; variant == SIZE_MID |-> prog_addr == {1'h0, pc[11:0]}; endproperty
    a_mid: assert property (p_mid) else $error("mid");
    property p_lrg; variant == SIZE_LARGE |-> prog_addr == pc; endproperty
    a_lrg: assert property (p_lrg) else $error("large");
    property p_sfr; direct_offset inside {[7'h01:7'h1F]} && !(variant == SIZE_LARGE
        && bank_select_high) |-> data_region == REGION_SFR; endproperty
    a_sfr: assert property (p_sfr) else $error("sfr");
    property p_gpr; direct_offset >= 7'h70 |-> data_region == REGION_GPR; endproperty
    a_gpr: assert property (p_gpr) else $error("gpr");
    property p_big; variant == SIZE_LARGE && bank_select_high
        && direct_offset inside {[7'h10:7'h1F]} |-> data_region == REGION_GPR; endproperty
    a_big: assert property (p_big) else $error("upper bank ram");
    property p_ptr; data_write && direct_offset == 7'h04 |=> pointer_value == $past(data_wdata);
    endproperty
    a_ptr: assert property (p_ptr) else $error("pointer");
endmodule : memory_address_map_assertions

// *** dv/memory_address_map_test.sv ***
module memory_address_map_test;
    timeunit 1ns;
    timeprecision 1ps;
    import memory_address_map_pkg::*;
    logic core_clk = 0, rst = 1, pc_advance = 0, pc_load = 0, intr_take = 0, data_read = 0;
    logic data_write = 0, bank_select_low = 0, bank_select_high = 0, sfr_read, sfr_write;
    logic [12:0] pc_load_value = 13'h1ABC, pc, prog_addr;
    logic [7:0] data_wdata = 0, data_rdata, pointer_value, sfr_rdata;
    logic [6:0] direct_offset = 0, sfr_offset;
    logic [1:0] data_region;
    variant_type variant = SIZE_LARGE;
    int err_total = 0, compares = 0;
    // ==========
    // Clock, block and partner
    always #2.5 core_clk = ~core_clk;
    memory_address_map memory_address_map_i (.*);
    sfr_model sfr_model_i (.*);
    // Compare and count
    task automatic chk(input string n, input logic [12:0] s, input logic [12:0] e);
        compares++;
        if (s !== e)
        begin
            err_total++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    // One data cycle, strobes left up for sampling
    task automatic acc(input logic [8:0] a, input logic w, input logic [7:0] d);
        {bank_select_high, bank_select_low, direct_offset} = a;
        {data_write, data_read, data_wdata} = {w, !w, d};
        @(posedge core_clk) #1;
    endtask : acc
    task automatic t_prog();
        chk("pc", pc, 13'h0000);
        pc_load = 1;
        @(posedge core_clk) #1 pc_load = 0;
        chk("large", prog_addr, 13'h1ABC);
        variant = SIZE_MID;
        @(posedge core_clk) #1 chk("mid", prog_addr, 13'h0ABC);
        variant = SIZE_SMALL;
        @(posedge core_clk) #1 chk("small", prog_addr, 13'h02BC);
        {pc_advance, intr_take} = 2'b11;
        @(posedge core_clk) #1 chk("vector", pc, 13'h0004);
        intr_take = 0;
        @(posedge core_clk) #1 pc_advance = 0;
        chk("count", pc, 13'h0005);
        $display("prog done");
    endtask : t_prog
    task automatic t_data();
        variant = SIZE_LARGE;
        acc(9'h0A0, 1, 8'h5A);
        acc(9'h120, 1, 8'h96);
        acc(9'h004, 1, 8'h70);
        acc(9'h000, 1, 8'h3C);
        chk("ptr", pointer_value, 8'h70);
        acc(9'h1F0, 0, 0);
        chk("shared", data_rdata, 8'h3C);
        acc(9'h000, 0, 0);
        chk("indirect", data_rdata, 8'h3C);
        acc(9'h0A0, 0, 0);
        chk("bank", data_rdata, 8'h5A);
        chk("gpr", data_region, REGION_GPR);
        acc(9'h120, 0, 0);
        chk("bank2", data_rdata, 8'h96);
        acc(9'h110, 1, 8'hC3);
        acc(9'h110, 0, 0);
        chk("wide", data_rdata, 8'hC3);
        acc(9'h00B, 1, 8'h81);
        chk("sfr wr", sfr_write, 1'b1);
        chk("sfr off", sfr_offset, 7'h0B);
        acc(9'h18B, 0, 0);
        chk("sfr rd", sfr_read, 1'b1);
        chk("sfr", data_region, REGION_SFR);
        @(posedge core_clk) #1 chk("mirror", data_rdata, 8'h81);
        $display("data done");
    endtask : t_data
    // Reset, tests, verdict
    initial
    begin
        repeat (5) @(posedge core_clk);
        #1 rst = 0;
        t_prog();
        t_data();
        stop_test();
    end
    // Watchdog
    initial
    begin
        #2000 err_total++;
        stop_test();
    end
    task automatic stop_test();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test
endmodule : memory_address_map_test
bind memory_address_map memory_address_map_assertions memory_address_map_assertions_i (.*);

// *** dv/sfr_model.sv ***
module sfr_model
(
    input wire logic core_clk,
    input wire logic sfr_write,
    input wire logic [6:0] sfr_offset,
    input wire logic [7:0] data_wdata,
    output logic [7:0] sfr_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] regs_ff [32];
    // One physical copy behind every mirror
    always_ff @(posedge core_clk)
        if (sfr_write) regs_ff[sfr_offset[4:0]] <= data_wdata;
    assign sfr_rdata = regs_ff[sfr_offset[4:0]];
endmodule : sfr_model

// *** hdl/data_decode_if.sv ***
interface data_decode_if;
    import memory_address_map_pkg::*;
    logic [8:0] data_addr;
    logic [1:0] variant;
    region_type region;
    logic [8:0] gpr_index;
    logic [6:0] sfr_offset;

    modport requester (output data_addr, output variant, input region, input gpr_index,
        input sfr_offset);
    modport decoder (input data_addr, input variant, output region, output gpr_index,
        output sfr_offset);
endinterface : data_decode_if

// *** hdl/data_decoder.sv ***
`include "memory_address_map_defines.svh"

module data_decoder
(
    data_decode_if.decoder dif
);
    import memory_address_map_pkg::*;

    logic [1:0] bank;
    logic [6:0] offset;
    logic [8:0] idx;
    logic [8:0] depth;
    logic [6:0] sfr_top;
    logic wide_bank;

    // Large parts keep only sixteen special registers in banks 2 and 3
    assign wide_bank = (dif.variant == SIZE_LARGE) && bank[1];
    assign sfr_top = wide_bank ? `SFR_TOP_WIDE : `SFR_TOP;

    // Split a bank/offset data address
    assign bank = dif.data_addr[8:7];
    assign offset = dif.data_addr[6:0];
    assign dif.sfr_offset = offset;
    assign dif.gpr_index = idx;

    // Usable general purpose depth per variant
    always_comb
    begin
        if (dif.variant == SIZE_LARGE)
            depth = `GPR_DEPTH_LARGE;
        else if (dif.variant == SIZE_MID)
            depth = `GPR_DEPTH_MID;
        else
            depth = `GPR_DEPTH_SMALL;
    end

    // Linear RAM index: top 16 bytes of every bank share bank 0 storage
    always_comb
    begin
        idx = 9'h000;
        if (offset >= `SHARED_LOW)
            idx = {2'b00, offset - 7'h20};
        else if (wide_bank)
        begin
            if (bank[0])
                idx = 9'h110 + {2'b00, offset - 7'h10};
            else
                idx = 9'h0B0 + {2'b00, offset - 7'h10};
        end
        else
        begin
            case (bank)
                2'b00: idx = {2'b00, offset - 7'h20};
                2'b01: idx = 9'h060 + {2'b00, offset - 7'h20};
                2'b10: idx = 9'h0B0 + {2'b00, offset - 7'h20};
                default: idx = 9'h100 + {2'b00, offset - 7'h20};
            endcase
        end
    end

    // Region decode: low offsets are special registers
    always_comb
    begin
        if (offset <= sfr_top)
            dif.region = REGION_SFR;
        else if (idx < depth)
            dif.region = REGION_GPR;
        else
            dif.region = REGION_NONE;
    end
endmodule : data_decoder

// *** hdl/memory_address_map.sv ***
// What this block does
// - Thirteen-bit program counter supplies each program fetch address.
// - Program space is 2K, 4K or 8K words of 14 bits.
// - Addresses above the implemented size wrap into the first 2K or 4K.
// - Reset starts the counter at 0000h; an interrupt loads 0004h.
// - Two bank-select bits choose one of four data banks.
// - Each bank holds 128 locations with a seven-bit offset.
// - Low offsets map to special registers, higher ones to general RAM.
// - Mirrored special registers reach one physical register from several banks.
// - General RAM holds 128, 192 or 368 bytes by variant.
// - Every location is reachable directly or through the indirect pointer.
`include "memory_address_map_defines.svh"

module memory_address_map
(
    input wire logic core_clk,
    input wire logic rst,
    input wire memory_address_map_pkg::variant_type variant,
    input wire logic pc_advance,
    input wire logic pc_load,
    input wire logic [12:0] pc_load_value,
    input wire logic intr_take,
    output logic [12:0] pc,
    output logic [12:0] prog_addr,
    input wire logic bank_select_low,
    input wire logic bank_select_high,
    input wire logic [6:0] direct_offset,
    input wire logic data_read,
    input wire logic data_write,
    input wire logic [7:0] data_wdata,
    output logic [7:0] data_rdata,
    output logic [1:0] data_region,
    output logic [6:0] sfr_offset,
    output logic [7:0] pointer_value,
    output logic sfr_read,
    output logic sfr_write,
    input wire logic [7:0] sfr_rdata
);
    import memory_address_map_pkg::*;

    // ==========================================================
    // Program counter

    logic [12:0] pc_ff;
    logic [12:0] nxt_pc;
    logic [12:0] prog_mask;

    // Wrap mask for the variant
    function automatic logic [12:0] mask_for(input variant_type v);
        logic [12:0] m;
        m = `PROG_MASK_LARGE;
        if (v == SIZE_SMALL)
            m = `PROG_MASK_SMALL;
        else if (v == SIZE_MID)
            m = `PROG_MASK_MID;
        return m;
    endfunction : mask_for

    assign prog_mask = mask_for(variant);

    // Next counter value with interrupt priority
    always_comb
    begin
        if (intr_take)
            nxt_pc = `INTR_VECTOR;
        else if (pc_load)
            nxt_pc = pc_load_value;
        else if (pc_advance)
            nxt_pc = pc_ff + 13'h0001;
        else
            nxt_pc = pc_ff;
    end

    // Counter register
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            pc_ff <= `RESET_VECTOR;
        else
            pc_ff <= nxt_pc;
    end

    assign pc = pc_ff;
    assign prog_addr = pc_ff & prog_mask;

    // ==========================================================
    // Indirect pointer and data address

    // Accesses at offset zero go through the pointer

    // Pointer and address
    logic [7:0] pointer_ff;
    logic [7:0] nxt_pointer;
    logic use_indirect;
    logic [8:0] data_addr;

    // Decode results
    logic [6:0] eff_offset;
    logic sfr_hit;
    logic gpr_hit;
    logic window_hit;
    logic pointer_hit;

    // Storage and read path
    logic [7:0] ram_ff [`GPR_MAX_DEPTH];
    logic [7:0] ram_word;
    logic [7:0] nxt_rdata;
    logic [7:0] rdata_ff;

    // Offset zero is the indirect window, never a storage location
    function automatic logic is_window(input logic [6:0] off);
        return off == `INDIRECT_OFFSET;
    endfunction : is_window

    // Offset four holds the pointer, seen alike from every bank
    function automatic logic is_pointer(input logic [6:0] off);
        return off == `POINTER_OFFSET;
    endfunction : is_pointer

    // A direct access to the window follows the pointer instead
    assign use_indirect = is_window(direct_offset);

    // Nine-bit data address: bank bits over the offset, or the pointer
    // No separate upper pointer bit exists, so the high bank bit stands in
    always_comb
    begin
        if (use_indirect)
        begin
            data_addr = {bank_select_high, pointer_ff};
        end
        else
        begin
            data_addr = {bank_select_high, bank_select_low, direct_offset};
        end
    end

    // ==========================================================
    // Region decode
    // The decoder sees only the effective address, so direct and
    // indirect accesses share one map

    // Bundle between this block and its decoder
    data_decode_if ddif ();

    // Hand the effective address and the variant to the decoder
    assign ddif.data_addr = data_addr;
    assign ddif.variant = variant;

    // Bank split, special register range and RAM index
    data_decoder data_decoder_i
    (
        .dif(ddif.decoder)
    );

    // Offset within the bank of the effective address
    assign eff_offset = ddif.sfr_offset;

    // What the effective address lands on
    // Only special register space can hold the window or the pointer
    always_comb
    begin
        sfr_hit = 1'b0;
        gpr_hit = 1'b0;
        window_hit = 1'b0;
        pointer_hit = 1'b0;
        case (ddif.region)
            REGION_SFR:
            begin
                sfr_hit = 1'b1;
                window_hit = is_window(eff_offset);
                pointer_hit = is_pointer(eff_offset);
            end
            REGION_GPR:
            begin
                gpr_hit = 1'b1;
            end
            default:
            begin
                gpr_hit = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Indirect pointer
    // Reached at offset four of every bank, so it is kept here rather
    // than among the core's special registers

    // A write to offset four, direct or indirect, loads it
    always_comb
    begin
        if (data_write && pointer_hit)
        begin
            nxt_pointer = data_wdata;
        end
        else
        begin
            nxt_pointer = pointer_ff;
        end
    end

    // Pointer register
    // Cleared by reset, so a first indirect access lands on the window
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pointer_ff <= `POINTER_RESET;
        end
        else
        begin
            pointer_ff <= nxt_pointer;
        end
    end

    // ==========================================================
    // Special register strobes
    // Strobes are combinational and follow the core's request in the same cycle

    // The window and the pointer live here, so the core side never sees them
    // Unimplemented locations raise no strobe at all
    always_comb
    begin
        sfr_read = 1'b0;
        sfr_write = 1'b0;
        if (sfr_hit && !window_hit && !pointer_hit)
        begin
            sfr_read = data_read;
            sfr_write = data_write;
        end
    end

    // Same offset in every bank, so mirrors meet one physical register
    assign sfr_offset = eff_offset;

    // ==========================================================
    // General purpose RAM
    // One array for the largest variant; smaller variants leave the top unused

    // Writes land only where the variant implements RAM
    always_ff @(posedge core_clk)
    begin
        if (data_write && gpr_hit)
        begin
            ram_ff[ddif.gpr_index] <= data_wdata;
        end
    end

    // Word at the decoded index
    // Read every cycle; only a read strobe lets it reach the output
    assign ram_word = ram_ff[ddif.gpr_index];

    // ==========================================================
    // Read data
    // Unimplemented locations and the window read as zero

    // Pick the source for the addressed location
    always_comb
    begin
        if (gpr_hit)
        begin
            nxt_rdata = ram_word;
        end
        else if (pointer_hit)
        begin
            nxt_rdata = pointer_ff;
        end
        else if (sfr_hit && !window_hit)
        begin
            nxt_rdata = sfr_rdata;
        end
        else
        begin
            nxt_rdata = 8'h00;
        end
    end

    // Read data register
    // It holds its value between read strobes
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_ff <= `RDATA_RESET;
        end
        else if (data_read)
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ==========================================================
    // Outputs
    // Read data and pointer come from flip-flops, the region
    // follows the address in the same cycle

    // Data outputs straight from their registers
    assign data_rdata = rdata_ff;
    assign pointer_value = pointer_ff;

    // Region as decoded for the effective address
    assign data_region = ddif.region;

endmodule : memory_address_map

// *** hdl/memory_address_map_defines.svh ***
`ifndef MEMORY_ADDRESS_MAP_DEFINES_SVH
`define MEMORY_ADDRESS_MAP_DEFINES_SVH

// ==========================================================
// Program memory
`define PC_WIDTH 13
`define PROG_WORD_WIDTH 14
`define RESET_VECTOR 13'h0000
`define INTR_VECTOR 13'h0004
`define PROG_MASK_SMALL 13'h07FF
`define PROG_MASK_MID 13'h0FFF
`define PROG_MASK_LARGE 13'h1FFF

// ==========================================================
// Data memory
`define OFFSET_WIDTH 7
`define DATA_ADDR_WIDTH 9
`define SFR_TOP 7'h1F
`define SHARED_LOW 7'h70
`define GPR_MAX_DEPTH 368
`define GPR_INDEX_WIDTH 9
`define GPR_DEPTH_SMALL 9'h080
`define GPR_DEPTH_MID 9'h0C0
`define GPR_DEPTH_LARGE 9'h170
`define INDIRECT_OFFSET 7'h00
`define POINTER_OFFSET 7'h04
`define SFR_TOP_WIDE 7'h0F
`define POINTER_RESET 8'h00
`define RDATA_RESET 8'h00

`endif

// *** hdl/memory_address_map_pkg.sv ***
package memory_address_map_pkg;

    // Memory size of the variant
    typedef enum logic [1:0]
    {
        SIZE_SMALL = 2'b00,
        SIZE_MID = 2'b01,
        SIZE_LARGE = 2'b10
    } variant_type;

    // What a data address lands on
    typedef enum logic [1:0]
    {
        REGION_SFR = 2'b00,
        REGION_GPR = 2'b01,
        REGION_NONE = 2'b10
    } region_type;

endpackage : memory_address_map_pkg
